// >>> rtl/scp_pkg.sv
// ----------------------------------------------------------------------------
// Overview of operation
// - serial3 divide value is eight bits; divider ratio is value plus one
// - internal serial3 clock is the divided clock halved again
// - divider register bit 8 picks serial3 source: 0 internal, 1 external
// - external source reaches serial3 as is, bypassing divider and halving
// - serial3 divider register resets to zero: internal source, divide by one
// - timer select bit 0: 0 gives pll output over eight, 1 the 32 kHz clock
// - timer select register resets to zero, so pll over eight runs first
// - memory data bus register: sixteen pull-down disable bits, one per line
// - card data bus register: sixteen pull-down disable bits, one per line
// - all pull-down disable bits reset to zero, pull-downs stay connected
// - port e register: eight pull-down disable bits, one per pin
// ----------------------------------------------------------------------------
package scp_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ------------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SERIAL3_DIV_OFS = 8'h30;
	localparam logic [ADDR_W-1:0] TIMER_SEL_OFS   = 8'h34;
	localparam logic [ADDR_W-1:0] CLOCK_STAT_OFS  = 8'h38;
	localparam logic [ADDR_W-1:0] MEM_PD_OFS      = 8'h40;
	localparam logic [ADDR_W-1:0] CARD_PD_OFS     = 8'h44;
	localparam logic [ADDR_W-1:0] PORTE_PD_OFS    = 8'h48;

	// ------------------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------------------
	localparam int DIV_W            = 8;
	localparam int SRC_SEL_BIT      = 8;
	localparam int TIMER_SEL_BIT    = 0;
	localparam int BUS_PD_W         = 16;
	localparam int PORT_PD_W        = 8;
	localparam int STAT_BAUD_BIT    = 0;
	localparam int STAT_TIMER_BIT   = 1;
	localparam int STAT_EXT_BIT     = 2;
	localparam int STAT_SLOW_BIT    = 3;
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------------
	localparam int CLK_HZ        = 50_000_000;
	localparam int PLL_DIV       = 8;
	localparam int PLL_EDGE_W    = 2;
	localparam int SYNC_STAGES   = 2;

	typedef enum logic [1:0] {
		SCP_IDLE = 2'b01,
		SCP_RESP = 2'b10
	} scp_state_t;

endpackage : scp_pkg

// >>> rtl/scp_sync.sv
`timescale 1ns/100ps
module scp_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import scp_pkg::*;

	// ------------------------------------------------------------------------
	// two-stage synchroniser
	// ------------------------------------------------------------------------
	// the first stage feeds only the second; metastability settles there
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : scp_sync

// >>> rtl/scp_baud_div.sv
`timescale 1ns/100ps
module scp_baud_div #(
	parameter int DIV_W = scp_pkg::DIV_W
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [DIV_W-1:0] divide_value,
	input  wire logic             restart,
	output logic                  half_clock
);
	import scp_pkg::*;

	// ------------------------------------------------------------------------
	// divide by value+1, then toggle to halve
	// ------------------------------------------------------------------------
	logic [DIV_W-1:0] count_q;
	logic             half_q;
	logic             terminal;

	assign terminal = (count_q == divide_value);

	always_ff @(posedge sys_clk) begin
		if (rst || restart) begin
			count_q <= '0;
		end else if (terminal) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	// one toggle per divided period gives the extra divide by two
	always_ff @(posedge sys_clk) begin
		if (rst || restart) begin
			half_q <= 1'b0;
		end else if (terminal) begin
			half_q <= ~half_q;
		end
	end

	assign half_clock = half_q;

endmodule : scp_baud_div

// >>> rtl/scp_clock_pull_regs.sv
`timescale 1ns/100ps
module scp_clock_pull_regs #(
	parameter int DIV_W = scp_pkg::DIV_W
) (
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [scp_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [scp_pkg::DATA_W-1:0]       pwdata,
	input  wire logic [scp_pkg::STRB_W-1:0]       pstrb,
	output logic      [scp_pkg::DATA_W-1:0]       prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	input  wire logic                             serial3_ext_clock,
	input  wire logic                             pll_clock,
	input  wire logic                             slow_clock,
	output logic                                  serial3_baud_clock,
	output logic                                  timer_clock,
	output logic      [scp_pkg::BUS_PD_W-1:0]     memory_bus_pulldown_off,
	output logic      [scp_pkg::BUS_PD_W-1:0]     card_bus_pulldown_off,
	output logic      [scp_pkg::PORT_PD_W-1:0]    port_e_pulldown_off
);
	import scp_pkg::*;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// merge write data into a stored word lane by lane
	function automatic logic [DATA_W-1:0] merge_lanes(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] result;
		result = old_word;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return result;
	endfunction : merge_lanes

	// offsets that answer without an error
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic hit;
		unique case (addr)
			SERIAL3_DIV_OFS,
			TIMER_SEL_OFS,
			CLOCK_STAT_OFS,
			MEM_PD_OFS,
			CARD_PD_OFS,
			PORTE_PD_OFS: hit = 1'b1;
			default:      hit = 1'b0;
		endcase
		return hit;
	endfunction : is_mapped

	// ------------------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------------------
	// one wait state keeps pready, prdata and pslverr straight from flops
	// a write commits at the edge that ends the answer cycle, with pready high
	scp_state_t state_q;
	logic       access;
	logic       commit;
	logic       wr_commit;
	logic       take_access;

	assign access    = psel && penable;
	assign commit    = access && (state_q == SCP_RESP);
	assign wr_commit = commit && pwrite && is_mapped(paddr);
	assign take_access = access && (state_q == SCP_IDLE);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= SCP_IDLE;
		end else begin
			unique case (state_q)
				SCP_IDLE: begin
					if (access) begin
						state_q <= SCP_RESP;
					end
				end
				SCP_RESP: begin
					state_q <= SCP_IDLE;
				end
				default: begin
					state_q <= SCP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= take_access;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (take_access) begin
			pslverr <= !is_mapped(paddr);
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// serial3 clock divider register
	// ------------------------------------------------------------------------
	logic [DIV_W-1:0] serial3_divide_value_q;
	logic             serial3_source_select_q;
	logic             div_restart_q;
	logic [DATA_W-1:0] div_word;

	// only the ratio and source bits are kept; other lanes fall away
	assign div_word = merge_lanes(
		{{(DATA_W-DIV_W-1){1'b0}}, serial3_source_select_q, serial3_divide_value_q},
		pwdata, pstrb);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serial3_divide_value_q  <= REG_RESET[DIV_W-1:0];
			serial3_source_select_q <= REG_RESET[SRC_SEL_BIT];
		end else if (wr_commit && paddr == SERIAL3_DIV_OFS) begin
			serial3_divide_value_q  <= div_word[DIV_W-1:0];
			serial3_source_select_q <= div_word[SRC_SEL_BIT];
		end
	end

	// a new ratio restarts the divider so no stretched half period appears
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_restart_q <= 1'b0;
		end else begin
			div_restart_q <= wr_commit && (paddr == SERIAL3_DIV_OFS)
				&& (div_word[DIV_W-1:0] != serial3_divide_value_q);
		end
	end

	// ------------------------------------------------------------------------
	// timer clock select register
	// ------------------------------------------------------------------------
	// only lane 0 holds a writable bit; the switch is not glitch free
	logic timer_source_select_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_source_select_q <= REG_RESET[TIMER_SEL_BIT];
		end else if (wr_commit && paddr == TIMER_SEL_OFS && pstrb[0]) begin
			timer_source_select_q <= pwdata[TIMER_SEL_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// pull-down disable registers
	// ------------------------------------------------------------------------
	// software may change these at any time; one bit per line or pin
	logic [DATA_W-1:0] mem_pd_word;
	logic [DATA_W-1:0] card_pd_word;
	logic [DATA_W-1:0] porte_pd_word;

	assign mem_pd_word   = merge_lanes({{(DATA_W-BUS_PD_W){1'b0}}, memory_bus_pulldown_off},
		pwdata, pstrb);
	assign card_pd_word  = merge_lanes({{(DATA_W-BUS_PD_W){1'b0}}, card_bus_pulldown_off},
		pwdata, pstrb);
	assign porte_pd_word = merge_lanes({{(DATA_W-PORT_PD_W){1'b0}}, port_e_pulldown_off},
		pwdata, pstrb);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			memory_bus_pulldown_off <= REG_RESET[BUS_PD_W-1:0];
		end else if (wr_commit && paddr == MEM_PD_OFS) begin
			memory_bus_pulldown_off <= mem_pd_word[BUS_PD_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			card_bus_pulldown_off <= REG_RESET[BUS_PD_W-1:0];
		end else if (wr_commit && paddr == CARD_PD_OFS) begin
			card_bus_pulldown_off <= card_pd_word[BUS_PD_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_e_pulldown_off <= REG_RESET[PORT_PD_W-1:0];
		end else if (wr_commit && paddr == PORTE_PD_OFS) begin
			port_e_pulldown_off <= porte_pd_word[PORT_PD_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// input clocks into the bus clock domain
	// ------------------------------------------------------------------------
	// these are sampled levels, so each must stay below a quarter of sys_clk
	// pll_clock is never used as a clock here, only its synced edges are counted
	logic [2:0] clk_sync;
	logic       ext_level;
	logic       pll_level;
	logic       slow_level;
	logic       pll_prev_q;
	logic       pll_rise;

	scp_sync #(
		.W (3)
	) u_clk_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({slow_clock, pll_clock, serial3_ext_clock}),
		.sync_out (clk_sync)
	);

	assign ext_level  = clk_sync[0];
	assign pll_level  = clk_sync[1];
	assign slow_level = clk_sync[2];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pll_prev_q <= 1'b0;
		end else begin
			pll_prev_q <= pll_level;
		end
	end

	assign pll_rise = pll_level && !pll_prev_q;

	// ------------------------------------------------------------------------
	// pll over eight for the timer
	// ------------------------------------------------------------------------
	// four rising edges per half period make a square wave at one eighth
	// the edge count runs free, so the phase after a select change is arbitrary
	logic [PLL_EDGE_W-1:0] pll_edges_q;
	logic                  pll_div_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pll_edges_q <= '0;
		end else if (pll_rise) begin
			pll_edges_q <= pll_edges_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pll_div_q <= 1'b0;
		end else if (pll_rise && (&pll_edges_q)) begin
			pll_div_q <= ~pll_div_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_clock <= 1'b0;
		end else begin
			timer_clock <= timer_source_select_q ? slow_level : pll_div_q;
		end
	end

	// ------------------------------------------------------------------------
	// serial3 baud clock
	// ------------------------------------------------------------------------
	logic baud_half;

	scp_baud_div #(
		.DIV_W (DIV_W)
	) u_baud_div (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.divide_value (serial3_divide_value_q),
		.restart      (div_restart_q),
		.half_clock   (baud_half)
	);

	// external source bypasses both the divider and the halving stage
	// switching the source may leave one short baud period behind
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serial3_baud_clock <= 1'b0;
		end else if (serial3_source_select_q) begin
			serial3_baud_clock <= ext_level;
		end else begin
			serial3_baud_clock <= baud_half;
		end
	end

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// unused bits are built as zeros, so reserved fields always read zero
	// the status word is read only and carries synced levels for polling
	// prdata drops to zero outside the answer cycle so no stale word lingers
	logic [DATA_W-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		unique case (paddr)
			SERIAL3_DIV_OFS: begin
				rd_word[DIV_W-1:0]  = serial3_divide_value_q;
				rd_word[SRC_SEL_BIT] = serial3_source_select_q;
			end
			TIMER_SEL_OFS: begin
				rd_word[TIMER_SEL_BIT] = timer_source_select_q;
			end
			CLOCK_STAT_OFS: begin
				rd_word[STAT_BAUD_BIT]  = serial3_baud_clock;
				rd_word[STAT_TIMER_BIT] = timer_clock;
				rd_word[STAT_EXT_BIT]   = ext_level;
				rd_word[STAT_SLOW_BIT]  = slow_level;
			end
			MEM_PD_OFS: begin
				rd_word[BUS_PD_W-1:0] = memory_bus_pulldown_off;
			end
			CARD_PD_OFS: begin
				rd_word[BUS_PD_W-1:0] = card_bus_pulldown_off;
			end
			PORTE_PD_OFS: begin
				rd_word[PORT_PD_W-1:0] = port_e_pulldown_off;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= REG_RESET;
		end else if (take_access && !pwrite) begin
			prdata <= rd_word;
		end else begin
			prdata <= REG_RESET;
		end
	end

endmodule : scp_clock_pull_regs

// >>> tb/scp_clock_pull_regs_props.sv
`timescale 1ns/100ps
module scp_clock_pull_regs_props
	import scp_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_W-1:0]     paddr,
	input wire logic [DATA_W-1:0]     pwdata,
	input wire logic [STRB_W-1:0]     pstrb,
	input wire logic [DATA_W-1:0]     prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  serial3_ext_clock,
	input wire logic                  pll_clock,
	input wire logic                  slow_clock,
	input wire logic                  serial3_baud_clock,
	input wire logic                  timer_clock,
	input wire logic [BUS_PD_W-1:0]   memory_bus_pulldown_off,
	input wire logic [BUS_PD_W-1:0]   card_bus_pulldown_off,
	input wire logic [PORT_PD_W-1:0]  port_e_pulldown_off
);
	logic        commit;
	logic        src_q;
	logic [7:0]  div_q;
	logic [2:0]  age_q;
	assign commit = psel && penable && pready && pwrite;
	// ------------------------------------------------------------------------
	// shadow of the divider register, age since its last write
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			src_q <= 1'b0;
			div_q <= 8'h00;
		end else if (commit && paddr == SERIAL3_DIV_OFS) begin
			if (pstrb[1]) src_q <= pwdata[8];
			if (pstrb[0]) div_q <= pwdata[7:0];
		end
	end
	// a write with a new ratio restarts the divider, so toggling is only judged once it settles
	always_ff @(posedge sys_clk) begin
		if (rst || (commit && paddr == SERIAL3_DIV_OFS)) age_q <= 3'h0;
		else if (age_q != 3'h7) age_q <= age_q + 3'h1;
	end
	// ------------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	mem_write_a: assert property (commit && paddr == MEM_PD_OFS && pstrb[1:0] == 2'b11
		|=> memory_bus_pulldown_off == $past(pwdata[15:0])) else $error("memory pull-down write lost");
	card_write_a: assert property (commit && paddr == CARD_PD_OFS && pstrb[1:0] == 2'b11
		|=> card_bus_pulldown_off == $past(pwdata[15:0])) else $error("card pull-down write lost");
	porte_write_a: assert property (commit && paddr == PORTE_PD_OFS && pstrb[0]
		|=> port_e_pulldown_off == $past(pwdata[7:0])) else $error("port e pull-down write lost");
	pull_hold_a: assert property (!(pready && pwrite) |=>
		$stable({memory_bus_pulldown_off, card_bus_pulldown_off, port_e_pulldown_off}))
		else $error("pull-down bits moved without a write");
	bus_upper_zero_a: assert property (pready && !pwrite && (paddr == MEM_PD_OFS || paddr == CARD_PD_OFS)
		|-> prdata[31:16] == 16'h0000) else $error("reserved pull-down bits read nonzero");
	timer_upper_zero_a: assert property (pready && !pwrite && paddr == TIMER_SEL_OFS
		|-> prdata[31:1] == 31'h0) else $error("timer select upper bits nonzero");
	ext_pass_a: assert property (src_q && $past(src_q, 4)
		|-> serial3_baud_clock == $past(serial3_ext_clock, 3)) else $error("external clock not passed");
	div_one_a: assert property (age_q == 3'h7 && !src_q && div_q == 8'h00
		|-> serial3_baud_clock != $past(serial3_baud_clock)) else $error("divide by one not toggling");
endmodule : scp_clock_pull_regs_props

bind scp_clock_pull_regs scp_clock_pull_regs_props #(.DIV_W(DIV_W)) u_props (.sys_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .serial3_ext_clock, .pll_clock, .slow_clock,
	.serial3_baud_clock, .timer_clock, .memory_bus_pulldown_off, .card_bus_pulldown_off, .port_e_pulldown_off);

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import scp_pkg::*;
	logic                  sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic                  ext_clk, slow_clk, baud, tmr;
	logic [ADDR_W-1:0]     paddr;
	logic [DATA_W-1:0]     pwdata, prdata, rd;
	logic [STRB_W-1:0]     pstrb;
	logic [BUS_PD_W-1:0]   mem_off, card_off;
	logic [PORT_PD_W-1:0]  pe_off;
	logic [2:0]            pll_cnt = 3'h0;
	int                    fail_count, cmp_count, p;
	localparam logic [7:0] OFS [5] = '{SERIAL3_DIV_OFS, TIMER_SEL_OFS, MEM_PD_OFS, CARD_PD_OFS, PORTE_PD_OFS};
	localparam logic [31:0] MSK [5] = '{32'h0000_01FF, 32'h0000_0001, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_00FF};

	scp_clock_pull_regs u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial3_ext_clock(ext_clk), .pll_clock(pll_cnt[2]), .slow_clock(slow_clk),
		.serial3_baud_clock(baud), .timer_clock(tmr), .memory_bus_pulldown_off(mem_off),
		.card_bus_pulldown_off(card_off), .port_e_pulldown_off(pe_off));

	// pll stand-in: period of 8 system clocks, slow enough for the synchroniser
	always @(posedge sys_clk) pll_cnt <= pll_cnt + 3'h1;

	task automatic wrap_up;
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		// pready and prdata are looked at mid-cycle, where they are settled
		for (n = 0; n < 50; n++) begin
			@(negedge sys_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		if (n == 50) begin
			fail_count++;
			wrap_up();
		end
		@(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	// cycles from one rising edge of the chosen clock to the next, first edge skipped
	task automatic period(input bit t, output int q);
		int k, r;
		logic prev, cur;
		r = 0;
		q = 0;
		prev = t ? tmr : baud;
		for (k = 0; k < 2000 && r < 3; k++) begin
			@(negedge sys_clk);
			cur = t ? tmr : baud;
			if (cur && !prev) r++;
			if (r == 2) q++;
			prev = cur;
		end
		if (r < 3) begin
			fail_count++;
			wrap_up();
		end
	endtask : period

	task automatic t_reset;
		foreach (OFS[i]) begin
			apb(1'b0, OFS[i], 32'h0, 4'h0);
			check(rd, 32'h0000_0000);
		end
		check({mem_off, card_off}, 32'h0000_0000);
		check({24'h0, pe_off}, 32'h0000_0000);
	endtask : t_reset

	task automatic t_timer;
		period(1'b1, p);
		check(p, 32'd64);
		apb(1'b1, TIMER_SEL_OFS, 32'h0000_0001, 4'hF);
		fork
			repeat (20) begin
				repeat (8) @(posedge sys_clk);
				slow_clk <= ~slow_clk;
			end
			period(1'b1, p);
		join
		check(p, 32'd16);
	endtask : t_timer

	task automatic t_fill;
		foreach (OFS[i]) begin
			apb(1'b1, OFS[i], 32'hFFFF_FFFF, 4'hF);
			apb(1'b0, OFS[i], 32'h0, 4'h0);
			check(rd, MSK[i]);
		end
		check({mem_off, card_off}, 32'hFFFF_FFFF);
		check({24'h0, pe_off}, 32'h0000_00FF);
		apb(1'b1, MEM_PD_OFS, 32'h0, 4'h1);
		check({16'h0, mem_off}, 32'h0000_FF00);
		foreach (OFS[i]) apb(1'b1, OFS[i], 32'h0, 4'hF);
		check({mem_off, card_off}, 32'h0000_0000);
	endtask : t_fill

	task automatic t_err;
		apb(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
		check({31'h0, er}, 32'h1);
		apb(1'b0, 8'h3C, 32'h0, 4'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0000_0000);
		apb(1'b1, CLOCK_STAT_OFS, 32'hFFFF_FFFF, 4'hF);
		check({31'h0, er}, 32'h0);
		apb(1'b0, CLOCK_STAT_OFS, 32'h0, 4'h0);
		check({31'h0, er}, 32'h0);
		check(rd & 32'hFFFF_FFF0, 32'h0000_0000);
	endtask : t_err

	task automatic t_div;
		int n [3] = '{1, 3, 256};
		foreach (n[i]) begin
			apb(1'b1, SERIAL3_DIV_OFS, 32'(n[i] - 1), 4'hF);
			period(1'b0, p);
			check(p, 32'(2 * n[i]));
		end
	endtask : t_div

	task automatic t_ext;
		apb(1'b1, SERIAL3_DIV_OFS, 32'h0000_01FF, 4'hF);
		fork
			repeat (40) begin
				repeat (4) @(posedge sys_clk);
				ext_clk <= ~ext_clk;
			end
			period(1'b0, p);
		join
		check(p, 32'd8);
	endtask : t_ext

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, ext_clk, slow_clk} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_timer();
		t_fill();
		t_err();
		t_div();
		t_ext();
		wrap_up();
	end
endmodule : tb_top
